/* File: hw/rate_gen_pkg.sv */
// Purpose: constants shared by the serial rate generator
// Assumes: byte-wide register port, one system clock
// Notes:   offsets are word indices on the plain register port
package rate_gen_pkg;
   localparam int          ADDR_W          = 3;
   localparam int          DATA_W          = 8;
   localparam logic [2:0]  OFS_TX_CTRL     = 3'h0;
   localparam logic [2:0]  OFS_RX_CTRL     = 3'h1;
   localparam logic [2:0]  OFS_RATE_CTRL   = 3'h2;
   localparam logic [2:0]  OFS_DIV_HIGH    = 3'h3;
   localparam logic [2:0]  OFS_DIV_LOW     = 3'h4;
   localparam logic [2:0]  OFS_STATUS      = 3'h5;
   // field positions
   localparam int          BIT_HIGH_SPEED  = 2;
   localparam int          BIT_SYNC_MODE   = 4;
   localparam int          BIT_WIDE_DIV    = 3;
   localparam int          BIT_RC_UNIMPL   = 2;
   localparam logic [7:0]  TX_CTRL_RESET   = 8'h02;
   localparam logic [7:0]  TX_CTRL_WMASK   = 8'hFD;
   localparam logic [7:0]  RX_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  RX_CTRL_WMASK   = 8'hF8;
   localparam logic [7:0]  RATE_CTRL_RESET = 8'h40;
   localparam logic [7:0]  RATE_CTRL_WMASK = 8'hBB;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
   // prescale counts minus one (sub-tick divider)
   localparam logic [5:0]  PRE_64          = 6'h3F;
   localparam logic [5:0]  PRE_16          = 6'h0F;
   localparam logic [5:0]  PRE_4           = 6'h03;
   localparam logic [5:0]  PRE_ZERO        = 6'h00;
   localparam logic [15:0] DIV_ZERO        = 16'h0000;
   // prescaler increment step, one count per clock
   localparam logic [5:0]  PRE_ONE         = 6'h01;
endpackage

/* File: hw/serial_baud_rate_generator.sv */
// Purpose: programmable bit-rate divider with three-sample receive vote
// Assumes: receive pin synchronous to clk_sys; software keeps strobes one cycle
// Notes:   tick is one clk_sys pulse per bit period; three samples in the clocks just before each tick
//
// Decided for this implementation: the placing of the registers and the plain strobed port.

module serial_baud_rate_generator
   import rate_gen_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset_n,
   // register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic      [DATA_W-1:0]   reg_rdata,
   // serial side
   input  wire logic                receive_pin,
   output logic                     rate_tick,
   output logic                     receive_level,
   output logic                     sync_mode
);
   import rate_gen_pkg::*;

   logic [7:0]  tx_ctrl_reg,   tx_ctrl_next;
   logic [7:0]  rx_ctrl_reg,   rx_ctrl_next;
   logic [7:0]  rate_ctrl_reg, rate_ctrl_next;
   logic [7:0]  div_high_reg,  div_high_next;
   logic [7:0]  div_low_reg,   div_low_next;
   logic [7:0]  rdata_reg,     rdata_next;
   logic [5:0]  pre_cnt_reg,   pre_cnt_next;
   logic [15:0] div_cnt_reg,   div_cnt_next;
   logic        tick_reg,      tick_next;
   logic [2:0]  samp_reg,      samp_next;
   logic        level_reg,     level_next;
   logic        sync_reg,      sync_next;
   logic [15:0] divisor;
   logic [5:0]  pre_max;
   logic        div_write;
   logic        wide;
   logic        high_speed;
   logic        is_sync;

   assign wide       = rate_ctrl_reg[BIT_WIDE_DIV];
   assign high_speed = tx_ctrl_reg[BIT_HIGH_SPEED];
   assign is_sync    = tx_ctrl_reg[BIT_SYNC_MODE];
   assign divisor    = wide ? {div_high_reg, div_low_reg} : {BYTE_ZERO, div_low_reg};
   assign div_write  = reg_write && (reg_addr == OFS_DIV_HIGH || reg_addr == OFS_DIV_LOW);

   // prescale selection
   always_comb begin
      if (is_sync) begin
         pre_max = PRE_4;
      end else if (wide && high_speed) begin
         pre_max = PRE_4;
      end else if (wide || high_speed) begin
         pre_max = PRE_16;
      end else begin
         pre_max = PRE_64;
      end
   end

   // register file
   always_comb begin
      tx_ctrl_next   = tx_ctrl_reg;
      rx_ctrl_next   = rx_ctrl_reg;
      rate_ctrl_next = rate_ctrl_reg;
      div_high_next  = div_high_reg;
      div_low_next   = div_low_reg;
      rdata_next     = BYTE_ZERO;
      if (reg_write) begin
         unique case (reg_addr)
            OFS_TX_CTRL: begin
               tx_ctrl_next = (reg_wdata & TX_CTRL_WMASK) | (tx_ctrl_reg & ~TX_CTRL_WMASK);
            end
            OFS_RX_CTRL: begin
               rx_ctrl_next = (reg_wdata & RX_CTRL_WMASK) | (rx_ctrl_reg & ~RX_CTRL_WMASK);
            end
            OFS_RATE_CTRL: begin
               rate_ctrl_next = (reg_wdata & RATE_CTRL_WMASK)
                              | (rate_ctrl_reg & ~RATE_CTRL_WMASK);
            end
            OFS_DIV_HIGH: begin
               div_high_next = reg_wdata;
            end
            OFS_DIV_LOW: begin
               div_low_next = reg_wdata;
            end
            default: begin
            end
         endcase
      end
      if (reg_read) begin
         unique case (reg_addr)
            OFS_TX_CTRL:   rdata_next = tx_ctrl_reg;
            OFS_RX_CTRL:   rdata_next = rx_ctrl_reg;
            OFS_RATE_CTRL: rdata_next = rate_ctrl_reg;
            OFS_DIV_HIGH:  rdata_next = div_high_reg;
            OFS_DIV_LOW:   rdata_next = div_low_reg;
            OFS_STATUS:    rdata_next = {5'h00, sync_reg, level_reg, tick_reg};
            default:       rdata_next = BYTE_ZERO;
         endcase
      end
   end

   // rate timer: prescaler then divisor counter, both on clk_sys only
   always_comb begin
      pre_cnt_next = pre_cnt_reg;
      div_cnt_next = div_cnt_reg;
      tick_next    = 1'b0;
      if (div_write) begin
         // restart so a new rate does not wait out the old period
         pre_cnt_next = PRE_ZERO;
         div_cnt_next = DIV_ZERO;
      end else if (pre_cnt_reg >= pre_max) begin
         pre_cnt_next = PRE_ZERO;
         if (div_cnt_reg >= divisor) begin
            div_cnt_next = DIV_ZERO;
            tick_next    = 1'b1;
         end else begin
            div_cnt_next = div_cnt_reg + 16'h0001;
         end
      end else begin
         pre_cnt_next = pre_cnt_reg + PRE_ONE;
      end
   end

   // shift on every clock so the three samples ahead of a tick are always adjacent,
   // even when a mode write shortens the prescale in mid-period
   always_comb begin
      samp_next  = {samp_reg[1:0], receive_pin};
      level_next = level_reg;
      sync_next  = is_sync;
      if (tick_reg) begin
         // majority of three
         level_next = (samp_reg[0] & samp_reg[1]) | (samp_reg[1] & samp_reg[2])
                    | (samp_reg[0] & samp_reg[2]);
      end
   end

   // register file state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tx_ctrl_reg   <= TX_CTRL_RESET;
         rx_ctrl_reg   <= RX_CTRL_RESET;
         rate_ctrl_reg <= RATE_CTRL_RESET;
         div_high_reg  <= BYTE_ZERO;
         div_low_reg   <= BYTE_ZERO;
         rdata_reg     <= BYTE_ZERO;
      end else begin
         tx_ctrl_reg   <= tx_ctrl_next;
         rx_ctrl_reg   <= rx_ctrl_next;
         rate_ctrl_reg <= rate_ctrl_next;
         div_high_reg  <= div_high_next;
         div_low_reg   <= div_low_next;
         rdata_reg     <= rdata_next;
      end
   end

   // rate timer state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pre_cnt_reg <= PRE_ZERO;
         div_cnt_reg <= DIV_ZERO;
         tick_reg    <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         div_cnt_reg <= div_cnt_next;
         tick_reg    <= tick_next;
      end
   end

   // receive vote state; idle line level is high
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         samp_reg  <= 3'h7;
         level_reg <= 1'b1;
         sync_reg  <= 1'b0;
      end else begin
         samp_reg  <= samp_next;
         level_reg <= level_next;
         sync_reg  <= sync_next;
      end
   end

   assign reg_rdata     = rdata_reg;
   assign rate_tick     = tick_reg;
   assign receive_level = level_reg;
   assign sync_mode     = sync_reg;
endmodule

/* File: verification/rate_gen_props.sv */
// Purpose: port-level checks of the rate generator
// Assumes: one clock; strobes never overlap
// Notes:   mode and divisor are shadowed from writes to predict the period
module rate_gen_props
   import rate_gen_pkg::*;
(
   input wire logic              clk_sys, reset_n, reg_write, reg_read,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
   input wire logic              receive_pin, rate_tick, receive_level, sync_mode
);
   logic [7:0] tx_reg, rc_reg, hi_reg, lo_reg;
   logic       armed_reg;
   int         cnt_reg;
   int         per;
   wire        wide = rc_reg[BIT_WIDE_DIV];
   wire        fast = tx_reg[BIT_HIGH_SPEED];
   wire        dw = reg_write && reg_addr inside {OFS_DIV_HIGH, OFS_DIV_LOW};
   assign per = (tx_reg[BIT_SYNC_MODE] || wide && fast ? 4 : wide || fast ? 16 : 64)
                * ((wide ? {hi_reg, lo_reg} : lo_reg) + 1);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // timing is only predicted from a divisor write on, since config writes do not restart
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {tx_reg, rc_reg, hi_reg, lo_reg, armed_reg} <= '0;
         cnt_reg <= 0;
      end else begin
         if (reg_write && reg_addr == OFS_TX_CTRL) tx_reg <= reg_wdata;
         if (reg_write && reg_addr == OFS_RATE_CTRL) rc_reg <= reg_wdata;
         if (reg_write && reg_addr == OFS_DIV_HIGH) hi_reg <= reg_wdata;
         if (reg_write && reg_addr == OFS_DIV_LOW) lo_reg <= reg_wdata;
         armed_reg <= dw || armed_reg && !reg_write;
         cnt_reg <= dw ? 0 : rate_tick ? 1 : cnt_reg + 1;
      end
   end
   property p_tick_time; armed_reg && rate_tick |-> cnt_reg == per; endproperty
   a_tick_time: assert property (p_tick_time) else $error("tick off period");
   property p_tick_due; armed_reg && cnt_reg == per |-> rate_tick; endproperty
   a_tick_due: assert property (p_tick_due) else $error("tick missing");
   property p_rd_low; reg_read && reg_addr == OFS_DIV_LOW |=> reg_rdata == lo_reg; endproperty
   a_rd_low: assert property (p_rd_low) else $error("low byte read");
   property p_rd_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data lingers");
   property p_rc_bits; reg_read && reg_addr == OFS_RATE_CTRL
      |=> reg_rdata[BIT_WIDE_DIV] == wide && !reg_rdata[BIT_RC_UNIMPL]; endproperty
   a_rc_bits: assert property (p_rc_bits) else $error("rate control bits");
   property p_sync; sync_mode == $past(tx_reg[BIT_SYNC_MODE]); endproperty
   a_sync: assert property (p_sync) else $error("sync copy");
   property p_vote; rate_tick |=> receive_level == ($past(receive_pin, 2)
      + $past(receive_pin, 3) + $past(receive_pin, 4) > 1); endproperty
   a_vote: assert property (p_vote) else $error("vote wrong");
   property p_hold; !rate_tick |=> $stable(receive_level); endproperty
   a_hold: assert property (p_hold) else $error("level moved");
   c_tick: cover property (armed_reg && rate_tick);
   c_sync: cover property (sync_mode);
   c_glitch: cover property (rate_tick && receive_pin != $past(receive_pin));
endmodule
bind serial_baud_rate_generator rate_gen_props chk (.*);

/* File: verification/serial_peer.sv */
// Purpose: serial peer driving the receive pin
// Assumes: moves to its next bit on each rate tick
// Notes:   glitch flips one cycle in three, which a three-sample vote must reject
module serial_peer (
   input  wire logic clk_sys, reset_n, rate_tick, glitch,
   output logic      receive_pin
);
   logic [7:0] pat_reg;
   logic [1:0] ph_reg;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pat_reg <= 8'hC5;
         ph_reg <= 2'h0;
         receive_pin <= 1'b1;
      end else begin
         if (rate_tick) pat_reg <= {pat_reg[0], pat_reg[7:1]};
         ph_reg <= ph_reg == 2'h2 ? 2'h0 : ph_reg + 2'h1;
         receive_pin <= pat_reg[0] ^ (glitch && ph_reg == 2'h0);
      end
   end
endmodule

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the rate generator
// Assumes: 250 MHz clock, strobes set by non-blocking assignment after the edge
// Notes:   each mode is timed after its restarting write and once more free-running
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rate_gen_pkg::*;
   logic              clk_sys = 0, reset_n = 0, reg_write = 0, reg_read = 0, glitch = 0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
   logic              receive_pin, rate_tick, receive_level, sync_mode;
   int                n_fail = 0, tests_run = 0, cyc = 0;
   typedef struct {logic [7:0] tx, rc, hi, lo; int per;} row_s;
   // divisors chosen as rounded clock-to-rate ratios; sync rows keep divisor above 1
   row_s rows [6] = '{'{8'h00, 8'h00, 8'hFF, 8'h01, 128}, '{8'h04, 8'h00, 8'h00, 8'h02, 48},
      '{8'h00, 8'h08, 8'h00, 8'h03, 64}, '{8'h04, 8'h08, 8'h00, 8'h02, 12},
      '{8'h14, 8'h00, 8'hFF, 8'h02, 12}, '{8'h10, 8'h08, 8'h01, 8'h02, 1036}};
   logic [7:0] rst [8] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   serial_baud_rate_generator dut (.*);
   serial_peer peer (.*);
   initial forever #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 20000) begin
      n_fail++;
      finish_test();
   end
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // counts edges from the previous tick or divisor write up to the next tick
   task automatic per_chk(input int exp);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         #1 k++;
      end while (rate_tick !== 1'b1 && k < 5000);
      chk(k, exp);
   endtask
   task automatic finish_test();
      $display("checks=%0d failures=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      foreach (rst[i]) rd(3'(i), rst[i]);
      foreach (rows[i]) begin
         glitch <= i[0];
         wr(OFS_TX_CTRL, rows[i].tx);
         wr(OFS_RATE_CTRL, rows[i].rc);
         wr(OFS_DIV_HIGH, rows[i].hi);
         wr(OFS_DIV_LOW, rows[i].lo);
         per_chk(rows[i].per);
         per_chk(rows[i].per);
         chk(sync_mode, rows[i].tx[BIT_SYNC_MODE]);
      end
      rd(OFS_DIV_HIGH, 8'h01);
      repeat (500) @(posedge clk_sys);
      wr(OFS_DIV_LOW, 8'h00);
      per_chk(1028);
      wr(OFS_RATE_CTRL, 8'hFF);
      rd(OFS_RATE_CTRL, 8'hFB);
      wr(OFS_TX_CTRL, 8'h00);
      rd(OFS_TX_CTRL, 8'h02);
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      #1 chk({rate_tick, receive_level}, 2'b01);
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(OFS_RATE_CTRL, 8'h40);
      wr(OFS_DIV_LOW, 8'h00);
      per_chk(64);
      finish_test();
   end
endmodule
